/* dma_chan_consts.vh */
// Summary of operation
// - a data byte equal to the ignore byte is treated as don't-care during matching
// - ignore applies only with ignore_byte_on set and pattern mode active
// - busy flag reads 1 while channel active or enabled, else 0
// - match_length_select 1 compares two bytes, 0 compares one byte
// - direction 1 chains from lower neighbour, 0 from higher neighbour
// - chain direction has no effect unless chaining_allow is set
// - channel_on set enables the channel, clearing it suspends
// - events_while_off 1 records start/abort events while disabled, else discards them
// - chaining_allow permits start by a neighbour's completion
// - suspension finishes the current transaction; busy drops only afterwards
// - pattern mode terminates when data matches the pattern value: its low byte, or all 16 bits with match_length_select set
// - unimplemented control and pattern bits ignore writes and read zero
`ifndef DMA_CHAN_CONSTS_VH
`define DMA_CHAN_CONSTS_VH
`define OFS_CONTROL 4'h0
`define OFS_PATTERN 4'h4
`define OFS_IRQ_STAT 4'h8
`define OFS_IRQ_MASK 4'hc
`define CTL_WMASK 32'hff00_29f3
`define PAT_WMASK 32'h0000_ffff
`define BIT_BUSY 15
`define BIT_IGN_ON 13
`define BIT_PATLEN 11
`define BIT_CHNS 8
`define BIT_ON 7
`define BIT_AED 6
`define BIT_CHN 5
`define BIT_PMODE 4
`define BIT_EDET 2
`define IRQ_BITS 3
`define IRQ_DONE 0
`define IRQ_MATCH 1
`define IRQ_ABORT 2
`endif

/* dma_chan_ctrl.v */
`timescale 1ns/1ns
`default_nettype none
`include "dma_chan_consts.vh"
module dma_chan_ctrl (
    input wire CLK_SYS,
    input wire SRST,
    input wire HSEL,
    input wire [31:0] HADDR,
    input wire [1:0] HTRANS,
    input wire HWRITE,
    input wire [2:0] HSIZE,
    input wire [31:0] HWDATA,
    input wire HREADY,
    output reg [31:0] HRDATA,
    output wire HREADYOUT,
    output wire HRESP,
    input wire START_EVT,
    input wire ABORT_EVT,
    input wire CHAIN_DONE_LOWER,
    input wire CHAIN_DONE_HIGHER,
    input wire DATA_VALID,
    input wire [7:0] DATA_BYTE,
    input wire XFER_LAST,
    input wire XFER_ACK,
    output reg XFER_REQ,
    output wire [1:0] PRIORITY_LEVEL,
    output reg XFER_DONE,
    output wire IRQ
);
    // control bits; bit 4 holds the pattern terminate mode selector
    reg [31:0] control;
    reg [15:0] match_pattern_value;
    reg [2:0] irq_stat;
    reg [2:0] irq_mask;
    reg busy;
    reg in_flight;
    reg pending;
    reg event_detected;
    reg [7:0] prev_byte;
    reg have_prev;
    reg wr_pend;
    reg [3:0] wr_addr;

    wire channel_on = control[`BIT_ON];
    wire [7:0] pattern_ignore_byte = control[31:24];
    wire ignore_byte_on = control[`BIT_IGN_ON];
    wire match_length_select = control[`BIT_PATLEN];
    wire chain_direction_select = control[`BIT_CHNS];
    wire events_while_off = control[`BIT_AED];
    wire chaining_allow = control[`BIT_CHN];
    wire pattern_mode = control[`BIT_PMODE];

    // bus address phase capture
    wire addr_ok = HSEL && HTRANS[1] && HREADY;
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign PRIORITY_LEVEL = control[1:0];
    assign IRQ = |(irq_stat & irq_mask);

    // chain trigger: direction only counts when chaining is allowed
    wire chain_hit = chaining_allow &&
        (chain_direction_select ? CHAIN_DONE_LOWER : CHAIN_DONE_HIGHER);

    // events seen while off are kept only when allowed
    wire evt_take = channel_on || events_while_off;
    wire start_ok = START_EVT && evt_take;
    wire abort_ok = ABORT_EVT && evt_take;

    // byte comparison with optional don't-care byte
    wire ign_act = ignore_byte_on && pattern_mode;
    wire lo_eq = (DATA_BYTE == match_pattern_value[7:0]) ||
        (ign_act && DATA_BYTE == pattern_ignore_byte);
    wire hi_eq = (prev_byte == match_pattern_value[15:8]) ||
        (ign_act && prev_byte == pattern_ignore_byte);
    wire pat_hit = pattern_mode && DATA_VALID && in_flight && lo_eq &&
        (!match_length_select || (have_prev && hi_eq));

    // write path and register writes
    wire do_wr = wr_pend;
    wire [31:0] ctl_w = (control & ~`CTL_WMASK) | (HWDATA & `CTL_WMASK);

    always @(posedge CLK_SYS) begin
        if (SRST) begin
            wr_pend <= 1'b0;
            wr_addr <= 4'h0;
        end else begin
            wr_pend <= addr_ok && HWRITE;
            wr_addr <= HADDR[3:0];
        end
    end

    // register state, software writes and hardware updates
    always @(posedge CLK_SYS) begin
        if (SRST) begin
            control <= 32'h0000_0000;
            match_pattern_value <= 16'h0000;
            irq_mask <= 3'h0;
        end else begin
            if (do_wr && wr_addr == `OFS_CONTROL) begin
                control <= ctl_w;
            end else if (do_wr && wr_addr == `OFS_PATTERN) begin
                match_pattern_value <= HWDATA[15:0];
            end else if (do_wr && wr_addr == `OFS_IRQ_MASK) begin
                irq_mask <= HWDATA[2:0];
            end
            // besides a control write, only a chain start turns the channel on; a pending start does not
            if (chain_hit && !channel_on) begin
                control[`BIT_ON] <= 1'b1;
            end
            // completion, match or abort disable the channel
            if (in_flight && XFER_ACK && (XFER_LAST || pat_hit)) begin
                control[`BIT_ON] <= 1'b0;
            end else if (abort_ok) begin
                control[`BIT_ON] <= 1'b0;
            end
        end
    end

    // transfer engine: one request outstanding; suspend waits for its ack
    always @(posedge CLK_SYS) begin
        if (SRST) begin
            in_flight <= 1'b0;
            pending <= 1'b0;
            XFER_REQ <= 1'b0;
            XFER_DONE <= 1'b0;
            busy <= 1'b0;
        end else begin
            XFER_DONE <= 1'b0;
            if (abort_ok) begin
                pending <= 1'b0;
            end else if (start_ok || chain_hit) begin
                pending <= 1'b1;
            end
            if (in_flight) begin
                if (XFER_ACK) begin
                    in_flight <= 1'b0;
                    XFER_REQ <= 1'b0;
                    if (XFER_LAST || pat_hit) begin
                        XFER_DONE <= 1'b1;
                        pending <= 1'b0;
                    end
                end
            end else if (channel_on && pending && !abort_ok) begin
                in_flight <= 1'b1;
                XFER_REQ <= 1'b1;
            end
            // busy holds until the in-flight transaction has ended
            busy <= channel_on || in_flight;
        end
    end

    // byte history for two-byte matching
    always @(posedge CLK_SYS) begin
        if (SRST) begin
            prev_byte <= 8'h00;
            have_prev <= 1'b0;
        end else if (!channel_on) begin
            have_prev <= 1'b0;
        end else if (DATA_VALID) begin
            prev_byte <= DATA_BYTE;
            have_prev <= 1'b1;
        end
    end

    // event flag: set wins over the disable clear
    always @(posedge CLK_SYS) begin
        if (SRST) begin
            event_detected <= 1'b0;
        end else if (start_ok || abort_ok) begin
            event_detected <= 1'b1;
        end else if (!channel_on) begin
            event_detected <= 1'b0;
        end
    end

    // sticky interrupt status, write one to clear, set wins
    wire [2:0] irq_set = {abort_ok, pat_hit && XFER_ACK, XFER_DONE};
    wire [2:0] irq_clr = (do_wr && wr_addr == `OFS_IRQ_STAT) ? HWDATA[2:0] : 3'h0;
    always @(posedge CLK_SYS) begin
        if (SRST) begin
            irq_stat <= 3'h0;
        end else begin
            irq_stat <= (irq_stat & ~irq_clr) | irq_set;
        end
    end

    // read data registered in the data phase; unmapped reads return zero
    always @(posedge CLK_SYS) begin
        if (SRST) begin
            HRDATA <= 32'h0000_0000;
        end else if (addr_ok && !HWRITE) begin
            if (HADDR[3:0] == `OFS_CONTROL) begin
                HRDATA <= (control & `CTL_WMASK) | {16'h0000, busy, 12'h000,
                    event_detected, 2'b00};
            end else if (HADDR[3:0] == `OFS_PATTERN) begin
                HRDATA <= {16'h0000, match_pattern_value};
            end else if (HADDR[3:0] == `OFS_IRQ_STAT) begin
                HRDATA <= {29'h0, irq_stat};
            end else if (HADDR[3:0] == `OFS_IRQ_MASK) begin
                HRDATA <= {29'h0, irq_mask};
            end else begin
                HRDATA <= 32'h0000_0000;
            end
        end
    end
endmodule // dma_chan_ctrl
`default_nettype wire

/* dma_chan_ctrl_chk.sv */
`timescale 1ns/1ns
`default_nettype none
module dma_chan_ctrl_chk (
    input wire logic CLK_SYS, SRST, HREADYOUT, HRESP,
    input wire logic XFER_REQ, XFER_ACK, XFER_LAST, XFER_DONE
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (SRST);
    // the slave has no wait states and only answers okay
    a_bus_okay: assert property (HREADYOUT && !HRESP) else $error("bus stall or error");
    a_req_hold: assert property (XFER_REQ && !XFER_ACK |=> XFER_REQ)
        else $error("request dropped early");
    a_req_drop: assert property (XFER_REQ && XFER_ACK |=> !XFER_REQ)
        else $error("request kept after ack");
    // a finished block clears its pending start, so no request follows done
    a_req_gap: assert property (XFER_DONE |=> !XFER_REQ)
        else $error("request right after done");
    a_last_done: assert property (XFER_REQ && XFER_ACK && XFER_LAST |=> XFER_DONE)
        else $error("no done after last");
    a_done_cause: assert property (XFER_DONE |-> $past(XFER_REQ && XFER_ACK))
        else $error("done without ack");
    a_done_pulse: assert property (XFER_DONE |=> !XFER_DONE) else $error("done too long");
    a_done_idle: assert property (XFER_DONE |-> !XFER_REQ) else $error("done while busy");
endmodule // dma_chan_ctrl_chk
bind dma_chan_ctrl dma_chan_ctrl_chk chk_inst (.*);
`default_nettype wire

/* dma_chan_ctrl_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module dma_chan_ctrl_tb;
    logic CLK_SYS = 0, SRST = 1, HSEL = 0, HWRITE = 0, lst = 1;
    logic [1:0] HTRANS = 0;
    logic [31:0] HADDR = 0, HWDATA = 0, r;
    logic [3:0] ev = 0, dly = 0;
    logic [7:0] b0 = 0, b1 = 0;
    int err_total = 0, comparisons = 0, i;
    wire HREADYOUT, HRESP, XFER_REQ, XFER_DONE, IRQ, ack, last, vld;
    wire [31:0] HRDATA;
    wire [1:0] PRIORITY_LEVEL;
    wire [7:0] dat;
    // {control, event index, done expected}
    logic [18:0] ct [5] = '{{16'h0120, 2'd3, 1'b0}, {16'h0120, 2'd2, 1'b1},
        {16'h0020, 2'd2, 1'b0}, {16'h0020, 2'd3, 1'b1}, {16'h0100, 2'd2, 1'b0}};
    // {control, earlier byte, byte at ack, done expected}
    logic [48:0] pt [7] = '{{32'h0890, 8'h12, 8'h34, 1'b1}, {32'h0890, 8'h12, 8'h35, 1'b0},
        {32'h0090, 8'h55, 8'h34, 1'b1}, {32'h0890, 8'h55, 8'h34, 1'b0},
        {32'h7700_2890, 8'h77, 8'h34, 1'b1}, {32'h7700_0890, 8'h77, 8'h34, 1'b0},
        {32'h7700_2880, 8'h12, 8'h34, 1'b0}};
    always #4 CLK_SYS = ~CLK_SYS;
    dma_chan_ctrl dma_chan_ctrl_inst (.CLK_SYS(CLK_SYS), .SRST(SRST), .HSEL(HSEL),
        .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'b010), .HWDATA(HWDATA),
        .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
        .START_EVT(ev[0]), .ABORT_EVT(ev[1]), .CHAIN_DONE_LOWER(ev[2]),
        .CHAIN_DONE_HIGHER(ev[3]), .DATA_VALID(vld), .DATA_BYTE(dat), .XFER_LAST(last),
        .XFER_ACK(ack), .XFER_REQ(XFER_REQ), .PRIORITY_LEVEL(PRIORITY_LEVEL),
        .XFER_DONE(XFER_DONE), .IRQ(IRQ));
    dma_chan_mem dma_chan_mem_inst (.clk(CLK_SYS), .srst(SRST), .req(XFER_REQ),
        .last_in(lst), .dly(dly), .b0(b0), .b1(b1), .ack(ack), .last(last), .vld(vld),
        .dat(dat));
    task cmp(input string n, input logic [31:0] e, g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask
    // single word transfer; address held until hready, then data phase
    task bus(input logic w, input logic [31:0] a, d, output logic [31:0] q);
        HSEL <= 1; HTRANS <= 2'b10; HADDR <= a; HWRITE <= w;
        do @(posedge CLK_SYS); while (HREADYOUT !== 1'b1);
        HSEL <= 0; HTRANS <= 2'b00; HWDATA <= d;
        do @(posedge CLK_SYS); while (HREADYOUT !== 1'b1);
        q = HRDATA;
    endtask
    task evt(input logic [1:0] k);
        ev <= 4'b0001 << k;
        @(posedge CLK_SYS);
        ev <= 4'b0000;
    endtask
    // a fixed window longer than the slowest transfer
    task done(input logic e);
        logic g;
        g = 0;
        repeat (40) begin
            @(posedge CLK_SYS);
            if (XFER_DONE === 1'b1) g = 1;
        end
        cmp("done", {31'h0, e}, {31'h0, g});
    endtask
    task irqc(input logic e);
        @(posedge CLK_SYS);
        #1 cmp("irq", {31'h0, e}, {31'h0, IRQ});
    endtask
    task conclude;
        $display("mismatches %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #200000;
        err_total++;
        conclude;
    end
    initial begin
        repeat (4) @(posedge CLK_SYS);
        SRST <= 0;
        bus(1, 0, 32'hffff_ff7f, r);
        bus(0, 0, 0, r);
        cmp("ctl", 32'hff00_2973, r);
        cmp("prio", 32'h3, {30'h0, PRIORITY_LEVEL});
        bus(1, 4, ~32'h0, r);
        bus(0, 4, 0, r);
        cmp("pat", 32'h0000_ffff, r);
        bus(1, 0, 0, r);
        evt(0);
        bus(1, 0, 32'h80, r);
        done(0);
        dly <= 8;
        evt(0);
        bus(0, 0, 0, r);
        cmp("busy", 32'h8084, r);
        done(1);
        bus(0, 0, 0, r);
        cmp("idle", 0, r);
        dly <= 0;
        bus(1, 0, 32'h40, r);
        evt(0);
        bus(1, 0, 32'hc0, r);
        done(1);
        bus(0, 8, 0, r);
        cmp("stat", 1, r);
        irqc(0);
        bus(1, 'hc, 1, r);
        irqc(1);
        bus(1, 8, 1, r);
        irqc(0);
        for (i = 0; i < 5; i++) begin
            bus(1, 0, {16'h0, ct[i][18:3]}, r);
            evt(ct[i][2:1]);
            done(ct[i][0]);
        end
        lst <= 0;
        bus(1, 4, 32'h1234, r);
        // unmatched runs go on until aborted
        for (i = 0; i < 7; i++) begin
            bus(1, 0, pt[i][48:17], r);
            b0 <= pt[i][16:9];
            b1 <= pt[i][8:1];
            dly <= i[3:0];
            evt(0);
            done(pt[i][0]);
            evt(1);
            repeat (20) @(posedge CLK_SYS);
        end
        conclude;
    end
endmodule // dma_chan_ctrl_tb
`default_nettype wire

/* dma_chan_mem.sv */
`timescale 1ns/1ns
`default_nettype none
// bus-side responder: one byte before the ack, one byte with it
module dma_chan_mem (
    input wire logic clk, srst, req, last_in,
    input wire logic [3:0] dly,
    input wire logic [7:0] b0, b1,
    output logic ack, last, vld,
    output logic [7:0] dat
);
    logic [4:0] n;
    // released data toggles and last is inverted so a stale byte never looks valid
    always @(posedge clk) begin
        ack <= 1'b0;
        vld <= 1'b0;
        dat <= srst ? 8'h00 : ~dat;
        last <= ~last_in;
        n <= (srst || !req || ack) ? 5'h00 : n + 5'h01;
        if (req && !ack && n == {1'b0, dly}) begin
            vld <= 1'b1;
            dat <= b0;
        end
        if (req && !ack && n == {1'b0, dly} + 5'h01) begin
            ack <= 1'b1;
            vld <= 1'b1;
            dat <= b1;
            last <= last_in;
        end
    end
endmodule // dma_chan_mem
`default_nettype wire
